/* File: design/csc_cmd_top.sv */
// Command line interpreter for zero, level, interval and altitude settings
//
// Summary of operation
// RULE_01 - A line ends on CR then LF
// RULE_02 - X with level recalibrates, echoes zero value
// RULE_03 - Concentration arguments divided by the multiplier
// RULE_04 - Parameters 8 and 9 form auto-zero level
// RULE_05 - Host splits value into high, low bytes
// RULE_06 - Parameters 10 and 11 form fresh-air level
// RULE_07 - @ with two values stores both intervals
// RULE_08 - Interval set is echoed as supplied
// RULE_09 - Intervals carry exactly one decimal digit
// RULE_10 - Reset: auto-zero on, 1.0 and 8.0
// RULE_11 - @ with zero turns auto-zero off
// RULE_12 - Bare @ reports 0 or both intervals
// RULE_13 - S stores altitude 0..65536, echoes five digits
// RULE_14 - Lower-case s reports altitude, five digits
// RULE_15 - Multiplier is always one
// RULE_16 - Fresh-air zero uses parameters 10 and 11
// RULE_17 - Parameter write echoes index and byte
// RULE_18 - Bad or out-of-range lines change nothing
`default_nettype none

module csc_cmd_top
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// Received characters
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output var  logic        rx_ready,
	// Answer characters
	output var  logic [7:0]  tx_data,
	output var  logic        tx_valid,
	input  wire logic        tx_ready,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	// Settings
	output var  logic [15:0] zero_point,
	output var  logic        az_enable,
	output var  logic [15:0] az_level,
	output var  logic [15:0] fresh_level,
	output var  logic [16:0] alt_comp
);

	typedef enum logic [2:0] {
		ST_PARSE  = 3'b000,  // Collect a line
		ST_EXEC   = 3'b001,  // Check and apply
		ST_LETTER = 3'b010,  // Send answer letter
		ST_SPACE  = 3'b011,  // Send separator
		ST_CONV   = 3'b100,  // Wait for decimal digits
		ST_DIGIT  = 3'b101,  // Send digits
		ST_CR     = 3'b110,  // Send carriage return
		ST_LF     = 3'b111   // Send line feed
	} csc_state_t;

	csc_state_t  state;        // Sequencer state
	csc_state_t  next_state;   // Its next value
	csc_bcd_if   bcd_bus ();   // Converter bundle

	// Line collection
	logic [7:0]  cmd;          // Command letter
	logic        have_cmd;     // Letter captured
	logic        cr_seen;      // CR received
	logic        bad;          // Line malformed
	logic [1:0]  argc;         // Closed arguments
	logic        in_arg;       // Inside a number
	logic [19:0] acc [3];      // Argument values
	logic [2:0]  pt;           // Point seen per argument
	logic [1:0]  frac [3];     // Digits after point, saturating
	logic [16:0] init_tenths;  // Initial interval
	logic [16:0] reg_tenths;   // Regular interval
	logic [15:0] raw_reading;  // Current raw reading

	// Answer
	logic [7:0]  r_letter;     // Answer letter
	logic [1:0]  r_nf;         // Number of fields
	logic [16:0] r_f0;         // First field
	logic [16:0] r_f1;         // Second field
	csc_fmt_t    r_fmt;        // Field format
	logic        fidx;         // Field being sent
	logic [2:0]  pos;          // Digit position
	logic        lead;         // Non-zero digit already sent

	// Decode of the collected line
	logic        exec_ok;      // Line valid for its command
	logic [7:0]  next_letter;
	logic [1:0]  next_nf;
	logic [16:0] next_f0;
	logic [16:0] next_f1;
	csc_fmt_t    next_fmt;
	logic [15:0] conc;         // Scaled concentration

	logic        rx_fire;      // Character taken
	logic        sent;         // Character handed over
	logic        is_digit;
	logic [3:0]  dval;         // Digit value
	logic [19:0] acc_next;     // Current argument times ten plus digit
	logic [3:0]  dsel;         // Digit chosen for sending
	logic        dig_emit;     // Position produces a character
	logic        dig_last;     // Last position of the field
	logic [7:0]  dig_char;     // Character for this position

	assign rx_fire  = rx_valid && rx_ready;
	assign sent     = tx_valid && tx_ready;
	assign is_digit = (rx_data >= CH_0) && (rx_data <= CH_9);
	assign dval     = 4'(rx_data - CH_0);
	assign acc_next = 20'((acc[argc] << 3) + (acc[argc] << 1)) + {16'h0000, dval};

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------

	// Next state of the line and answer sequence
	always_comb begin
		next_state = state;
		unique case (state)
			ST_PARSE: begin
				if (rx_fire && rx_data == CH_LF && have_cmd && cr_seen && !bad) begin  // RULE_01
					next_state = ST_EXEC;
				end
			end
			ST_EXEC:   next_state = exec_ok ? ST_LETTER : ST_PARSE;  // RULE_18
			ST_LETTER: if (sent) next_state = (r_nf == 2'h0) ? ST_CR : ST_SPACE;
			ST_SPACE:  if (sent) next_state = ST_CONV;
			ST_CONV:   if (bcd_bus.done) next_state = ST_DIGIT;
			ST_DIGIT: begin
				if (sent && dig_last) begin
					next_state = ({1'b0, fidx} + 2'h1 == r_nf) ? ST_CR : ST_SPACE;
				end
			end
			ST_CR:     if (sent) next_state = ST_LF;
			ST_LF:     if (sent) next_state = ST_PARSE;
		endcase
	end

	// State register; input accepted only while collecting
	always_ff @(posedge clock) begin
		if (srst) begin
			state    <= ST_PARSE;
			rx_ready <= 1'b0;
		end else begin
			state    <= next_state;
			rx_ready <= (next_state == ST_PARSE);
		end
	end

	// ------------------------------------------------------------
	// Line collection
	// ------------------------------------------------------------

	// Characters build the letter and up to three numbers
	always_ff @(posedge clock) begin
		if (srst || state == ST_EXEC) begin
			cmd      <= 8'h00;
			have_cmd <= 1'b0;
			cr_seen  <= 1'b0;
			bad      <= 1'b0;
			argc     <= 2'h0;
			in_arg   <= 1'b0;
			pt       <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				acc[i]  <= 20'h00000;
				frac[i] <= 2'h0;
			end
		end else if (rx_fire) begin
			if (rx_data == CH_LF) begin
				// Good lines are cleared by the execute step
				if (!(have_cmd && cr_seen && !bad)) begin  // RULE_01
					have_cmd <= 1'b0;
					cr_seen  <= 1'b0;
					bad      <= 1'b0;
					argc     <= 2'h0;
					in_arg   <= 1'b0;
					pt       <= 3'h0;
				end
			end else if (cr_seen) begin
				bad <= 1'b1;  // RULE_01
			end else if (rx_data == CH_CR) begin
				cr_seen <= 1'b1;
				if (in_arg) begin
					argc   <= argc + 2'h1;
					in_arg <= 1'b0;
				end
			end else if (!have_cmd) begin
				cmd      <= rx_data;
				have_cmd <= 1'b1;
			end else if (rx_data == CH_SP) begin
				if (in_arg) begin
					argc   <= argc + 2'h1;
					in_arg <= 1'b0;
				end
			end else if (is_digit) begin
				if (!in_arg) begin
					// A fourth argument can never be legal
					if (argc == 2'h3) begin
						bad <= 1'b1;  // RULE_18
					end else begin
						acc[argc]  <= {16'h0000, dval};
						frac[argc] <= 2'h0;
						pt[argc]   <= 1'b0;
						in_arg     <= 1'b1;
					end
				end else if (acc[argc] >= ACC_LIMIT) begin
					bad <= 1'b1;  // RULE_18
				end else begin
					acc[argc] <= acc_next;
					if (pt[argc] && frac[argc] != 2'h3) begin
						frac[argc] <= frac[argc] + 2'h1;
					end
				end
			end else if (rx_data == CH_DOT && in_arg && !pt[argc]) begin
				pt[argc] <= 1'b1;
			end else begin
				bad <= 1'b1;  // RULE_18
			end
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------

	// Checks arguments and prepares the answer
	always_comb begin
		exec_ok     = 1'b0;
		next_letter = cmd;
		next_nf     = 2'h1;
		next_f0     = 17'h00000;
		next_f1     = 17'h00000;
		next_fmt    = FMT_PAD5;
		conc        = 16'(acc[0] / VALUE_MULT);  // RULE_03 RULE_15
		case (cmd)
			CMD_ZERO_KNOWN: begin
				exec_ok = (argc == 2'h1) && !pt[0] && (acc[0] <= CONC_MAX);  // RULE_18
				next_f0 = {1'b0, 16'(raw_reading - conc)};  // RULE_02
			end
			CMD_ZERO_FRESH: begin
				exec_ok = (argc == 2'h0);
				next_f0 = {1'b0, 16'(raw_reading - fresh_level)};  // RULE_16
			end
			CMD_PARAM: begin
				exec_ok = (argc == 2'h2) && (pt[1:0] == 2'b00) && (acc[1] <= BYTE_MAX)
					&& (acc[0] >= PAR_AZ_HI) && (acc[0] <= PAR_FRESH_LO);  // RULE_18
				// Level bytes answer in lower case, fresh-air bytes in upper
				next_letter = (acc[0] <= PAR_AZ_LO) ? CMD_PARAM_LOW : CMD_PARAM;  // RULE_17
				next_nf     = 2'h2;
				next_f0     = acc[0][16:0];  // RULE_17
				next_f1     = acc[1][16:0];
			end
			CMD_INTERVAL: begin
				next_fmt = FMT_PLAIN;
				if (argc == 2'h0) begin
					exec_ok = 1'b1;
					if (az_enable) begin  // RULE_12
						next_nf  = 2'h2;
						next_fmt = FMT_TENTHS;
						next_f0  = init_tenths;
						next_f1  = reg_tenths;
					end
				end else if (argc == 2'h1) begin
					exec_ok = !pt[0] && (acc[0] == 20'h00000);  // RULE_11
				end else if (argc == 2'h2) begin
					exec_ok = (pt[1:0] == 2'b11) && (frac[0] == 2'h1) && (frac[1] == 2'h1)
						&& (acc[0] <= TENTHS_MAX) && (acc[1] <= TENTHS_MAX);  // RULE_09
					next_nf  = 2'h2;
					next_fmt = FMT_TENTHS;  // RULE_08
					next_f0  = acc[0][16:0];
					next_f1  = acc[1][16:0];
				end
			end
			CMD_ALT_SET: begin
				exec_ok = (argc == 2'h1) && !pt[0] && (acc[0] <= ALT_MAX);  // RULE_13
				next_f0 = acc[0][16:0];
			end
			CMD_ALT_GET: begin
				exec_ok = (argc == 2'h0);
				next_f0 = alt_comp;  // RULE_14
			end
			default: exec_ok = 1'b0;  // Other letters belong elsewhere
		endcase
	end

	// ------------------------------------------------------------
	// Stored settings
	// ------------------------------------------------------------

	// Only a checked line reaches here, so bad lines leave all alone
	always_ff @(posedge clock) begin
		if (srst) begin
			zero_point  <= RST_ZERO;
			az_enable   <= 1'b1;  // RULE_10
			init_tenths <= RST_INIT_TENTHS;  // RULE_10
			reg_tenths  <= RST_REG_TENTHS;  // RULE_10
			az_level    <= RST_AZ_LEVEL;
			fresh_level <= RST_FRESH_LEVEL;
			alt_comp    <= RST_ALT;  // RULE_13
		end else if (state == ST_EXEC && exec_ok) begin
			case (cmd)
				CMD_ZERO_KNOWN, CMD_ZERO_FRESH: zero_point <= next_f0[15:0];  // RULE_02
				CMD_PARAM: begin
					// Each byte lands alone, so either order works
					if (acc[0] == PAR_AZ_HI) az_level[15:8] <= acc[1][7:0];  // RULE_04 RULE_05
					if (acc[0] == PAR_AZ_LO) az_level[7:0] <= acc[1][7:0];  // RULE_04
					if (acc[0] == PAR_FRESH_HI) fresh_level[15:8] <= acc[1][7:0];  // RULE_06
					if (acc[0] == PAR_FRESH_LO) fresh_level[7:0] <= acc[1][7:0];  // RULE_06
				end
				CMD_INTERVAL: begin
					if (argc == 2'h1) begin
						az_enable <= 1'b0;  // RULE_11
					end else if (argc == 2'h2) begin
						init_tenths <= acc[0][16:0];  // RULE_07
						reg_tenths  <= acc[1][16:0];  // RULE_07
						az_enable   <= 1'b1;
					end
				end
				CMD_ALT_SET: alt_comp <= acc[0][16:0];  // RULE_13
				default: ;  // Queries store nothing
			endcase
		end
	end

	// ------------------------------------------------------------
	// Answer digits
	// ------------------------------------------------------------

	// Picks the digit and decides whether this position prints
	always_comb begin
		dsel     = bcd_bus.bcd[3:0];
		dig_last = (pos == 3'h4);
		dig_emit = 1'b1;
		case (pos)
			3'h0:    dsel = bcd_bus.bcd[19:16];
			3'h1:    dsel = bcd_bus.bcd[15:12];
			3'h2:    dsel = bcd_bus.bcd[11:8];
			3'h3:    dsel = bcd_bus.bcd[7:4];
			3'h4:    dsel = (r_fmt == FMT_TENTHS) ? bcd_bus.bcd[3:0] : bcd_bus.bcd[3:0];
			default: dsel = bcd_bus.bcd[3:0];
		endcase
		dig_char = CH_0 + {4'h0, dsel};
		if (r_fmt == FMT_TENTHS) begin
			// Integer part unpadded, then point, then the tenths digit
			dig_last = (pos == 3'h5);
			if (pos == 3'h4) begin
				dig_char = CH_DOT;  // RULE_08
			end else if (pos < 3'h4) begin
				dig_emit = lead || (dsel != 4'h0) || (pos == 3'h3);
			end
		end else if (r_fmt == FMT_PLAIN) begin
			dig_emit = lead || (dsel != 4'h0) || (pos == 3'h4);  // RULE_12
		end
	end

	// ------------------------------------------------------------
	// Answer sender
	// ------------------------------------------------------------

	// One character in flight; the sink may hold it as long as it likes
	always_ff @(posedge clock) begin
		if (srst) begin
			tx_valid      <= 1'b0;
			tx_data       <= 8'h00;
			r_letter      <= 8'h00;
			r_nf          <= 2'h0;
			r_f0          <= 17'h00000;
			r_f1          <= 17'h00000;
			r_fmt         <= FMT_PAD5;
			fidx          <= 1'b0;
			pos           <= 3'h0;
			lead          <= 1'b0;
			bcd_bus.start <= 1'b0;
			bcd_bus.bin   <= 17'h00000;
		end else begin
			bcd_bus.start <= 1'b0;
			if (sent) begin
				tx_valid <= 1'b0;
			end
			unique case (state)
				ST_PARSE: ;
				ST_EXEC: begin
					r_letter <= next_letter;
					r_nf     <= next_nf;
					r_f0     <= next_f0;
					r_f1     <= next_f1;
					r_fmt    <= next_fmt;
					fidx     <= 1'b0;
				end
				ST_LETTER, ST_SPACE, ST_CR, ST_LF: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data  <= (state == ST_LETTER) ? r_letter :
							(state == ST_SPACE) ? CH_SP :
							(state == ST_CR) ? CH_CR : CH_LF;
					end
					if (state == ST_SPACE && sent) begin
						bcd_bus.start <= 1'b1;
						bcd_bus.bin   <= fidx ? r_f1 : r_f0;
					end
				end
				ST_CONV: begin
					pos  <= 3'h0;
					lead <= 1'b0;
				end
				ST_DIGIT: begin
					if (sent) begin
						pos <= pos + 3'h1;
						if (dig_last) fidx <= 1'b1;
					end else if (!tx_valid) begin
						if (dig_emit) begin
							tx_valid <= 1'b1;
							tx_data  <= dig_char;
							if (pos < 3'h4) lead <= lead || (dsel != 4'h0);
						end else begin
							pos <= pos + 3'h1;  // Leading zero skipped
						end
					end
				end
			endcase
		end
	end

	csc_bcd_conv u_conv (
		.clock (clock),
		.srst  (srst),
		.bus   (bcd_bus.conv)
	);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------

	// Raw reading is supplied by software and feeds the zero calculation
	always_ff @(posedge clock) begin
		if (srst) begin
			raw_reading <= RST_RAW;
		end else if (reg_wr && reg_addr == REG_RAW) begin
			raw_reading <= reg_wdata[15:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (srst || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_addr)
				REG_RAW:    reg_rdata <= {16'h0000, raw_reading};
				REG_ZERO:   reg_rdata <= {16'h0000, zero_point};
				REG_AZ_EN:  reg_rdata <= {31'h00000000, az_enable};
				REG_INIT:   reg_rdata <= {15'h0000, init_tenths};
				REG_REGU:   reg_rdata <= {15'h0000, reg_tenths};
				REG_LEVELS: reg_rdata <= {az_level, fresh_level};
				REG_ALT:    reg_rdata <= {15'h0000, alt_comp};
				default:    reg_rdata <= 32'h00000000;  // Unmapped reads zero
			endcase
		end
	end

endmodule : csc_cmd_top

`default_nettype wire

/* File: design/csc_pkg.sv */
// Shared constants and types for the calibration settings command interpreter
`default_nettype none

package csc_pkg;

	// ------------------------------------------------------------
	// Character codes
	// ------------------------------------------------------------
	localparam logic [7:0] CH_CR  = 8'h0d;  // Carriage return
	localparam logic [7:0] CH_LF  = 8'h0a;  // Line feed
	localparam logic [7:0] CH_SP  = 8'h20;  // Space
	localparam logic [7:0] CH_DOT = 8'h2e;  // Decimal point
	localparam logic [7:0] CH_0   = 8'h30;  // Digit zero
	localparam logic [7:0] CH_9   = 8'h39;  // Digit nine

	// ------------------------------------------------------------
	// Command letters
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_ZERO_KNOWN = 8'h58;  // Zero at known level
	localparam logic [7:0] CMD_ZERO_FRESH = 8'h47;  // Zero in fresh air
	localparam logic [7:0] CMD_PARAM      = 8'h50;  // Parameter write
	localparam logic [7:0] CMD_PARAM_LOW  = 8'h70;  // Ack letter, level bytes
	localparam logic [7:0] CMD_INTERVAL   = 8'h40;  // Auto-zero intervals
	localparam logic [7:0] CMD_ALT_SET    = 8'h53;  // Altitude set
	localparam logic [7:0] CMD_ALT_GET    = 8'h73;  // Altitude query

	// ------------------------------------------------------------
	// Parameter indices and limits
	// ------------------------------------------------------------
	localparam logic [19:0] PAR_AZ_HI    = 20'h00008;  // Auto-zero level MSB
	localparam logic [19:0] PAR_AZ_LO    = 20'h00009;  // Auto-zero level LSB
	localparam logic [19:0] PAR_FRESH_HI = 20'h0000a;  // Fresh-air level MSB
	localparam logic [19:0] PAR_FRESH_LO = 20'h0000b;  // Fresh-air level LSB
	localparam logic [19:0] VALUE_MULT   = 20'h00001;  // Measurement multiplier
	localparam logic [19:0] CONC_MAX     = 20'h0ffff;  // Largest concentration
	localparam logic [19:0] BYTE_MAX     = 20'h000ff;  // Largest byte
	localparam logic [19:0] ALT_MAX      = 20'h10000;  // Largest altitude value
	localparam logic [19:0] TENTHS_MAX   = 20'h1869f;  // Five printable digits
	localparam logic [19:0] ACC_LIMIT    = 20'h186a0;  // Accumulator guard

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [15:0] RST_AZ_LEVEL    = 16'h0190;   // 400
	localparam logic [15:0] RST_FRESH_LEVEL = 16'h0190;   // 400
	localparam logic [16:0] RST_INIT_TENTHS = 17'h0000a;  // 1.0 day
	localparam logic [16:0] RST_REG_TENTHS  = 17'h00050;  // 8.0 days
	localparam logic [16:0] RST_ALT         = 17'h02000;  // 8192
	localparam logic [15:0] RST_ZERO        = 16'h0000;   // Zero point
	localparam logic [15:0] RST_RAW         = 16'h0000;   // Raw reading

	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [3:0] REG_RAW    = 4'h0;  // Raw reading, read/write
	localparam logic [3:0] REG_ZERO   = 4'h1;  // Zero point
	localparam logic [3:0] REG_AZ_EN  = 4'h2;  // Auto-zero enable
	localparam logic [3:0] REG_INIT   = 4'h3;  // Initial interval, tenths
	localparam logic [3:0] REG_REGU   = 4'h4;  // Regular interval, tenths
	localparam logic [3:0] REG_LEVELS = 4'h5;  // Auto-zero and fresh levels
	localparam logic [3:0] REG_ALT    = 4'h6;  // Altitude compensation

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	localparam logic [4:0] BCD_BITS = 5'h11;  // Binary input width, 17

	typedef enum logic [1:0] {
		FMT_PAD5   = 2'b00,  // Five zero-padded digits
		FMT_PLAIN  = 2'b01,  // No leading zeros
		FMT_TENTHS = 2'b10   // Integer, point, one digit
	} csc_fmt_t;

endpackage : csc_pkg

`default_nettype wire

/* File: design/csc_bcd_if.sv */
// Request and answer bundle between interpreter and decimal converter
`default_nettype none

interface csc_bcd_if;
	logic        start;  // One-cycle conversion request
	logic [16:0] bin;    // Binary value, held with start
	logic        done;   // One-cycle completion pulse
	logic [19:0] bcd;    // Five decimal digits, low digit lowest

	modport conv (input start, input bin, output done, output bcd);
	modport user (output start, output bin, input done, input bcd);
endinterface : csc_bcd_if

`default_nettype wire

/* File: design/csc_bcd_conv.sv */
// Serial binary to five-digit decimal converter
`default_nettype none

module csc_bcd_conv
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Converter bundle
	csc_bcd_if.conv   bus
);

	logic [16:0] shift;  // Bits still to shift in
	logic [19:0] work;   // Partial decimal result
	logic [4:0]  count;  // Shifts remaining
	logic        busy;   // Conversion running
	logic [19:0] adj;    // Digits after add-three

	// ------------------------------------------------------------
	// Add three to any digit of five or more
	// ------------------------------------------------------------
	for (genvar g = 0; g < 5; g++) begin : g_adj
		assign adj[g*4 +: 4] = (work[g*4 +: 4] >= 4'h5) ? work[g*4 +: 4] + 4'h3 : work[g*4 +: 4];
	end

	// One bit per cycle keeps area tiny; latency is far below a byte time
	always_ff @(posedge clock) begin
		if (srst) begin
			shift    <= 17'h00000;
			work     <= 20'h00000;
			count    <= 5'h00;
			busy     <= 1'b0;
			bus.done <= 1'b0;
			bus.bcd  <= 20'h00000;
		end else begin
			bus.done <= 1'b0;
			if (bus.start) begin
				shift <= bus.bin;
				work  <= 20'h00000;
				count <= BCD_BITS;
				busy  <= 1'b1;
			end else if (busy) begin
				work  <= {adj[18:0], shift[16]};
				shift <= {shift[15:0], 1'b0};
				count <= count - 5'h01;
				if (count == 5'h01) begin
					busy     <= 1'b0;
					bus.done <= 1'b1;
					bus.bcd  <= {adj[18:0], shift[16]};
				end
			end
		end
	end

endmodule : csc_bcd_conv

`default_nettype wire

/* File: sim/csc_cmd_top_asserts.sv */
// Port checker for the command interpreter
`default_nettype none
module csc_cmd_top_asserts
	import csc_pkg::*;
(
	// Clock, reset and characters
	input wire logic        clock,
	input wire logic        srst,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	// Register port and settings
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] zero_point,
	input wire logic        az_enable,
	input wire logic [15:0] az_level,
	input wire logic [15:0] fresh_level,
	input wire logic [16:0] alt_comp
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// Reset check runs during reset itself, so no disable
	property p_rst; disable iff (1'b0) srst |=> alt_comp == RST_ALT && az_enable && az_level == RST_AZ_LEVEL; endproperty
	a_rst: assert property (p_rst) else $error("reset defaults");
	property p_eol; rx_valid && rx_ready && rx_data == CH_CR
		##1 rx_valid && rx_ready && rx_data == CH_LF |=> !rx_ready; endproperty
	a_eol: assert property (p_eol) else $error("line end");
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("answer hold");
	property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
	a_gap: assert property (p_gap) else $error("answer gap");
	property p_done; tx_valid && tx_ready && tx_data == CH_LF |-> ##[1:2] rx_ready; endproperty
	a_done: assert property (p_done) else $error("line done");
	// Settings may only move while a line executes
	property p_quiet; !$stable({zero_point, az_enable, az_level, fresh_level, alt_comp}) |-> !$past(rx_ready); endproperty
	a_quiet: assert property (p_quiet) else $error("setting moved");
	property p_alt_reg; reg_rd && reg_addr == REG_ALT |=> reg_rdata == {15'h0, $past(alt_comp)}; endproperty
	a_alt_reg: assert property (p_alt_reg) else $error("altitude read");
	property p_alt_max; alt_comp <= ALT_MAX; endproperty
	a_alt_max: assert property (p_alt_max) else $error("altitude range");
endmodule : csc_cmd_top_asserts
bind csc_cmd_top csc_cmd_top_asserts chk (.*);
`default_nettype wire

/* File: sim/csc_host_model.sv */
// Host model: sends command lines and gathers the answer line
`default_nettype none
module csc_host_model (
	// Clock
	input  wire logic       clock,
	// Command characters
	output var  logic [7:0] rx_data,
	output var  logic       rx_valid,
	input  wire logic       rx_ready,
	// Answer characters
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output var  logic       tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [159:0] ans = '0;  // Answer text, last char lowest
	bit           slow = 0;  // Sink stalls when set
	bit           tick = 0;  // Stall pattern
	initial rx_valid = 1'b0;
	initial rx_data = 8'h00;
	initial tx_ready = 1'b1;
	// Gather taken chars; stall every other cycle when slow
	always @(posedge clock) begin
		tick <= !tick;
		tx_ready <= !slow || tick;
		if (tx_valid && tx_ready)
			ans <= {ans[151:0], tx_data};
	end
	// Each char is held until taken; released data is inverted, not left stale
	task automatic send(input string s);
		string t;
		t = {s, "\r\n"};
		ans = '0;
		for (int i = 0; i < t.len(); i++) begin
			rx_data <= t[i];
			rx_valid <= 1'b1;
			do @(posedge clock); while (!rx_ready);
		end
		rx_valid <= 1'b0;
		rx_data <= ~t[t.len() - 1];
	endtask : send
endmodule : csc_host_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the command interpreter
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench
	import csc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 0, srst = 1, reg_wr = 0, reg_rd = 0;
	logic        rx_valid, rx_ready, tx_valid, tx_ready, az_enable;
	logic [7:0]  rx_data, tx_data;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] zero_point, az_level, fresh_level;
	logic [16:0] alt_comp;
	int          num_errors = 0, samples_checked = 0, cycles = 0;
	csc_cmd_top uut (.*);
	csc_host_model host (.*);
	initial forever #12.5 clock = ~clock;
	// Hang guard, well above the longest sequence
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		`CHK("reg", e, reg_rdata)
		@(posedge clock);
	endtask : rd
	// Send a line, wait for the answer's LF; zero means refused
	task automatic run(input string c, input logic [159:0] e);
		int n;
		host.send(c);
		for (n = 0; host.ans[7:0] !== CH_LF && n < 400; n++)
			@(posedge clock);
		`CHK(c, e, host.ans)
	endtask : run
	initial begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rd(REG_AZ_EN, 32'h1);
		rd(REG_INIT, 32'ha);
		rd(REG_REGU, 32'h50);
		rd(REG_LEVELS, 32'h01900190);
		rd(4'hf, 32'h0);
		run("s", "s 08192\r\n");
		run("@", "@ 1.0 8.0\r\n");
		run("S 65536", "S 65536\r\n");
		run("S 65537", '0);
		rd(REG_ALT, 32'h10000);
		host.slow = 1;
		run("@ 2.5 12.0", "@ 2.5 12.0\r\n");
		rd(REG_REGU, 32'h78);
		run("@ 1.25 3.0", '0);
		run("@ 0", "@ 0\r\n");
		run("@", "@ 0\r\n");
		`CHK("az_enable", 1'b0, az_enable)
		host.slow = 0;
		// 2000 split as 7 and 208, high byte first
		run("P 8 7", "p 00008 00007\r\n");
		run("P 9 208", "p 00009 00208\r\n");
		run("P 9 256", '0);
		run("P 10 0", "P 00010 00000\r\n");
		run("P 11 250", "P 00011 00250\r\n");
		rd(REG_LEVELS, 32'h07d000fa);
		wr(REG_RAW, 32'hbb8);
		run("X 1000", "X 02000\r\n");
		`CHK("zero", 16'h07d0, zero_point)
		run("G", "G 02750\r\n");
		run("X 70000", '0);
		rd(REG_ZERO, 32'habe);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
